// ==== hw/safety_escalation_pkg.sv ====
// constants and types for the safety error reaction and escalation manager
// Contract
// - raise errors in normal and special mode
// - three error classes: non-fatal, ordinary, fatal
// - two warning classes: quiet and reacting
// - reacting warnings behave as non-fatal errors
// - launch configured stopping reaction per class
// - failed reaction escalates to next higher class
// - completed reaction activates torque-off and brake control
// - any error clears the status ok bit; encoder, brake and ack-output faults leave it set
// - hold prior acknowledgment, acknowledge after transition
// - coasting axis unsafe, standstill makes it safe
// - encoder, brake, ack-output faults: permanently unsafe
// - system faults enter safe default state
// - config field bits select class reactions
// - flag mismatch with standard control at transition
// - master decelerates within tolerance time
// - keep prior monitors during master/return reactions
// - quick stop: deceleration monitor or tolerance time
package safety_escalation_pkg;
    // stopping configuration field layout
    localparam int CFG_W = 17;
    localparam int NF_FIELD_LSB = 0;
    localparam int ORD_FIELD_LSB = 4;
    localparam int FIELD_W = 4;
    localparam int MASTER_BIT = 16;
    localparam int CHECK_W = 8;
    // reaction codes of a class field
    localparam logic [3:0] RX_VEL_RESET = 4'h0;
    localparam logic [3:0] RX_TORQUE_OFF = 4'h1;
    localparam logic [3:0] RX_QUICK_STOP = 4'h2;
    localparam logic [3:0] RX_RETURN = 4'h3;
    localparam logic [3:0] RX_RAMP_ESTOP = 4'h4;
    // tolerance time base: one tick per millisecond
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    localparam int TICK_W = 15;
    localparam int TOL_W = 16;
    localparam int LOCAL_OUT_W = 4;
    // reset values
    localparam logic STATUS_OK_RST = 1'b1;
    localparam logic [TOL_W-1:0] TOL_RST = 16'h0000;

    typedef enum logic [2:0] {
        CL_NONE = 3'b000,
        CL_WARN_QUIET = 3'b001,
        CL_WARN_REACT = 3'b010,
        CL_NONFATAL = 3'b011,
        CL_ORDINARY = 3'b100,
        CL_FATAL = 3'b101
    } class_t;

    typedef enum logic [2:0] {
        R_NONE = 3'b000,
        R_VEL_RESET = 3'b001,
        R_TORQUE_OFF = 3'b010,
        R_QUICK_STOP = 3'b011,
        R_RETURN = 3'b100,
        R_RAMP_ESTOP = 3'b101,
        R_MASTER = 3'b110
    } react_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_REACT = 2'b01,
        ST_OFF = 2'b10,
        ST_DEFAULT = 2'b11
    } state_t;
endpackage

// ==== hw/safety_error_escalation.sv ====
// safety error reaction, supervision and escalation manager for one axis
`timescale 1ns/1ps
`default_nettype none
module safety_error_escalation
#(
    parameter int TICK_CYCLES = safety_escalation_pkg::TICK_CYCLES
)
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // monitoring triggers
    input wire logic i_mon_trig,
    input wire logic [2:0] i_mon_class,
    input wire logic i_special_mode,
    // configuration
    input wire logic [safety_escalation_pkg::CFG_W-1:0] i_stop_cfg,
    input wire logic [safety_escalation_pkg::CFG_W-1:0] i_std_cfg,
    input wire logic i_transition_cmd,
    input wire logic [safety_escalation_pkg::TOL_W-1:0] i_tol_nonfatal,
    input wire logic [safety_escalation_pkg::TOL_W-1:0] i_tol_ordinary,
    input wire logic i_enc_eval_active,
    input wire logic i_brake_cfg,
    // drive and axis feedback
    input wire logic i_reaction_done,
    input wire logic i_decel_trip,
    input wire logic i_torque_free,
    input wire logic i_standstill,
    input wire logic i_op_safe_ack,
    input wire logic i_err_clear,
    // fault sources
    input wire logic i_err_encoder,
    input wire logic i_err_brake,
    input wire logic i_err_ack_out,
    input wire logic i_sys_err_own,
    input wire logic i_fatal_std,
    // local outputs requested by normal operation
    input wire logic i_brake_open_req,
    input wire logic [safety_escalation_pkg::LOCAL_OUT_W-1:0] i_local_outs,
    // status
    output logic o_status_ok,
    output logic [2:0] o_err_class,
    output logic o_warn_quiet,
    output logic o_escalated,
    output logic o_cfg_err,
    output logic o_axis_safe,
    // drive reaction
    output logic [2:0] o_reaction,
    output logic o_master_stop_req,
    output logic o_return_req,
    output logic o_hold_monitors,
    // safe outputs
    output logic o_torque_off,
    output logic o_brake_ctl,
    output logic o_stage_lock,
    output logic o_brake_open,
    output logic [safety_escalation_pkg::LOCAL_OUT_W-1:0] o_local_outs
);
    typedef safety_escalation_pkg::class_t class_t;
    typedef safety_escalation_pkg::react_t react_t;
    typedef safety_escalation_pkg::state_t state_t;

    // warnings with reaction are handled as non-fatal errors
    function automatic class_t eff_class(input logic [2:0] raw);
        eff_class = class_t'(raw);
        if (raw == safety_escalation_pkg::CL_WARN_REACT)
            eff_class = safety_escalation_pkg::CL_NONFATAL;
    endfunction

    function automatic class_t next_class(input class_t cls);
        next_class = (cls == safety_escalation_pkg::CL_NONFATAL) ?
            safety_escalation_pkg::CL_ORDINARY : safety_escalation_pkg::CL_FATAL;
    endfunction

    // reaction chosen from the class field; illegal codes fall back to torque off
    function automatic react_t sel_reaction(input class_t cls,
        input logic [safety_escalation_pkg::CFG_W-1:0] cfg);
        logic [3:0] code;
        logic nf;
        nf = (cls == safety_escalation_pkg::CL_NONFATAL);
        code = nf ? cfg[safety_escalation_pkg::NF_FIELD_LSB +: safety_escalation_pkg::FIELD_W]
                  : cfg[safety_escalation_pkg::ORD_FIELD_LSB +: safety_escalation_pkg::FIELD_W];
        sel_reaction = safety_escalation_pkg::R_TORQUE_OFF;
        if (nf && cfg[safety_escalation_pkg::MASTER_BIT])
            sel_reaction = safety_escalation_pkg::R_MASTER;
        else if (nf || cls == safety_escalation_pkg::CL_ORDINARY)
        begin
            case (code)
                safety_escalation_pkg::RX_VEL_RESET: sel_reaction = safety_escalation_pkg::R_VEL_RESET;
                safety_escalation_pkg::RX_RAMP_ESTOP: sel_reaction = safety_escalation_pkg::R_RAMP_ESTOP;
                safety_escalation_pkg::RX_QUICK_STOP:
                    sel_reaction = nf ? safety_escalation_pkg::R_QUICK_STOP
                                      : safety_escalation_pkg::R_TORQUE_OFF;
                safety_escalation_pkg::RX_RETURN:
                    sel_reaction = nf ? safety_escalation_pkg::R_RETURN
                                      : safety_escalation_pkg::R_TORQUE_OFF;
                default: sel_reaction = safety_escalation_pkg::R_TORQUE_OFF;
            endcase
        end
    endfunction

    state_t state_r, state_nxt;
    class_t class_r, class_nxt;
    react_t react_r, react_nxt;
    logic [safety_escalation_pkg::TOL_W-1:0] tol_cnt_r, tol_cnt_nxt;
    logic [safety_escalation_pkg::TICK_W-1:0] tick_cnt_r;
    logic ack_hold_r;
    logic perm_unsafe_r, perm_unsafe_nxt;
    logic perm_safe_r, perm_safe_nxt;

    // trigger decode; accepted in normal and special mode alike
    wire class_t trig_cls = eff_class(i_mon_class);
    wire logic new_err = i_mon_trig && (trig_cls >= safety_escalation_pkg::CL_NONFATAL)
                         && (trig_cls <= safety_escalation_pkg::CL_FATAL);
    wire logic quiet_warn = i_mon_trig && (trig_cls == safety_escalation_pkg::CL_WARN_QUIET);
    wire logic sys_fault = i_sys_err_own || i_fatal_std;
    wire logic perm_fault = i_err_encoder || i_err_brake || i_err_ack_out;
    wire logic tick = (tick_cnt_r == safety_escalation_pkg::TICK_W'(TICK_CYCLES - 1));
    wire logic in_react = (state_r == safety_escalation_pkg::ST_REACT);

    // ramp-type reactions use the deceleration monitor when the encoder is evaluated
    wire logic ramp_rx = (react_r == safety_escalation_pkg::R_QUICK_STOP) ||
                         (react_r == safety_escalation_pkg::R_VEL_RESET) ||
                         (react_r == safety_escalation_pkg::R_RAMP_ESTOP);
    wire logic use_dmon = ramp_rx && i_enc_eval_active;
    wire logic tol_expired = (tol_cnt_r == safety_escalation_pkg::TOL_RST) && tick;
    wire logic sup_fail = in_react && (use_dmon ? i_decel_trip : tol_expired);

    // launch selection: the higher of escalation and a fresh trigger
    wire class_t esc_cls = next_class(class_r);
    wire class_t fresh_cls = new_err ? trig_cls : safety_escalation_pkg::CL_NONE;
    wire class_t launch_cls = (sup_fail && esc_cls > fresh_cls) ? esc_cls : fresh_cls;
    wire react_t launch_rx = sel_reaction(launch_cls, i_stop_cfg);
    wire logic launch = ((state_r == safety_escalation_pkg::ST_IDLE) && new_err) ||
                        (in_react && (sup_fail || (new_err && trig_cls > class_r)));
    wire logic [safety_escalation_pkg::TOL_W-1:0] launch_tol =
        (launch_cls == safety_escalation_pkg::CL_NONFATAL) ? i_tol_nonfatal : i_tol_ordinary;
    wire logic cfg_mismatch =
        (i_stop_cfg[safety_escalation_pkg::CHECK_W-1:0] != i_std_cfg[safety_escalation_pkg::CHECK_W-1:0])
        || (i_stop_cfg[safety_escalation_pkg::MASTER_BIT] != i_std_cfg[safety_escalation_pkg::MASTER_BIT]);

    // reaction sequencing; a system fault overrides the next state, while class and reaction still follow a launch in that cycle
    always_comb
    begin
        state_nxt = state_r;
        class_nxt = class_r;
        react_nxt = react_r;
        tol_cnt_nxt = (tick && tol_cnt_r != safety_escalation_pkg::TOL_RST) ?
                      tol_cnt_r - 1'b1 : tol_cnt_r;
        unique case (state_r)
            safety_escalation_pkg::ST_IDLE, safety_escalation_pkg::ST_REACT:
            begin
                if (launch)
                begin
                    class_nxt = launch_cls;
                    react_nxt = launch_rx;
                    tol_cnt_nxt = launch_tol;
                    state_nxt = (launch_rx == safety_escalation_pkg::R_TORQUE_OFF) ?
                                safety_escalation_pkg::ST_OFF : safety_escalation_pkg::ST_REACT;
                end
                else if (in_react && i_reaction_done)
                    state_nxt = safety_escalation_pkg::ST_OFF;
            end
            safety_escalation_pkg::ST_OFF:
            begin
                if (i_err_clear)
                begin
                    state_nxt = safety_escalation_pkg::ST_IDLE;
                    class_nxt = safety_escalation_pkg::CL_NONE;
                    react_nxt = safety_escalation_pkg::R_NONE;
                end
            end
            safety_escalation_pkg::ST_DEFAULT: state_nxt = safety_escalation_pkg::ST_DEFAULT;
        endcase
        if (sys_fault)
            state_nxt = safety_escalation_pkg::ST_DEFAULT;
    end

    // permanent safety verdicts; unsafe is held until reset
    assign perm_unsafe_nxt = perm_unsafe_r || perm_fault || sys_fault;
    assign perm_safe_nxt = (state_nxt != safety_escalation_pkg::ST_IDLE) &&
                           (perm_safe_r || (i_torque_free && i_standstill));

    // decoded output values, registered below
    wire logic err_nxt = (state_nxt != safety_escalation_pkg::ST_IDLE);
    wire logic off_nxt = (state_nxt == safety_escalation_pkg::ST_OFF) ||
                         (state_nxt == safety_escalation_pkg::ST_DEFAULT);
    wire logic dflt_nxt = (state_nxt == safety_escalation_pkg::ST_DEFAULT);
    wire logic react_st_nxt = (state_nxt == safety_escalation_pkg::ST_REACT);
    wire logic coasting = i_torque_free && !i_standstill && !perm_safe_nxt;
    wire logic ack_nxt = launch && !in_react ? i_op_safe_ack : ack_hold_r;
    wire logic safe_nxt =
        perm_unsafe_nxt ? 1'b0 :
        (perm_safe_nxt && off_nxt) ? 1'b1 :
        coasting && err_nxt ? 1'b0 :
        react_st_nxt ? ack_nxt :
        off_nxt ? 1'b1 : i_op_safe_ack;
    wire logic brake_ctl_nxt = off_nxt && (i_brake_cfg || dflt_nxt);
    wire logic keep_mon_nxt = react_st_nxt && ((react_nxt == safety_escalation_pkg::R_MASTER) ||
                              (react_nxt == safety_escalation_pkg::R_RETURN));

    // free running millisecond prescaler for the tolerance counter
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst || tick)
            tick_cnt_r <= '0;
        else
            tick_cnt_r <= tick_cnt_r + 1'b1;
    end

    // state registers
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            state_r <= safety_escalation_pkg::ST_IDLE;
            class_r <= safety_escalation_pkg::CL_NONE;
            react_r <= safety_escalation_pkg::R_NONE;
            tol_cnt_r <= safety_escalation_pkg::TOL_RST;
            ack_hold_r <= 1'b0;
            perm_unsafe_r <= 1'b0;
            perm_safe_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            class_r <= class_nxt;
            react_r <= react_nxt;
            tol_cnt_r <= tol_cnt_nxt;
            ack_hold_r <= ack_nxt;
            perm_unsafe_r <= perm_unsafe_nxt;
            perm_safe_r <= perm_safe_nxt;
        end
    end

    // status outputs straight from flip-flops
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_status_ok <= safety_escalation_pkg::STATUS_OK_RST;
            o_err_class <= safety_escalation_pkg::CL_NONE;
            o_warn_quiet <= 1'b0;
            o_escalated <= 1'b0;
            o_cfg_err <= 1'b0;
            o_axis_safe <= 1'b0;
        end
        else
        begin
            o_status_ok <= !err_nxt;
            o_err_class <= class_nxt;
            o_warn_quiet <= quiet_warn;
            o_escalated <= sup_fail && !sys_fault;
            if (i_transition_cmd)
                o_cfg_err <= cfg_mismatch;
            o_axis_safe <= safe_nxt;
        end
    end

    // drive reaction and safe outputs
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            o_reaction <= safety_escalation_pkg::R_NONE;
            o_master_stop_req <= 1'b0;
            o_return_req <= 1'b0;
            o_hold_monitors <= 1'b0;
            o_torque_off <= 1'b0;
            o_brake_ctl <= 1'b0;
            o_stage_lock <= 1'b0;
            o_brake_open <= 1'b0;
            o_local_outs <= '0;
        end
        else
        begin
            o_reaction <= react_nxt;
            o_master_stop_req <= react_st_nxt && react_nxt == safety_escalation_pkg::R_MASTER;
            o_return_req <= react_st_nxt && react_nxt == safety_escalation_pkg::R_RETURN;
            o_hold_monitors <= keep_mon_nxt;
            o_torque_off <= off_nxt;
            o_brake_ctl <= brake_ctl_nxt;
            o_stage_lock <= off_nxt;
            o_brake_open <= i_brake_open_req && !brake_ctl_nxt;
            o_local_outs <= dflt_nxt ? '0 : i_local_outs;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    sequence seq_idle_err;
        state_r == safety_escalation_pkg::ST_IDLE && new_err && !sys_fault;
    endsequence

    sequence seq_launch_master;
        launch && launch_rx == safety_escalation_pkg::R_MASTER && !sys_fault;
    endsequence

    chk_status_bit_clear: assert property (seq_idle_err |=> !o_status_ok && o_err_class != 3'b000)
        else $error("status ok bit not cleared on error");
    chk_quiet_warn_none: assert property (state_r == safety_escalation_pkg::ST_IDLE && !new_err
        && i_mon_trig && trig_cls == safety_escalation_pkg::CL_WARN_QUIET && !sys_fault
        |=> o_warn_quiet && o_status_ok && o_reaction == 3'b000)
        else $error("quiet warning caused a reaction");
    chk_warn_as_nonfatal: assert property (seq_idle_err ##0 (i_mon_class == 3'b010)
        |=> class_r == safety_escalation_pkg::CL_NONFATAL)
        else $error("reacting warning not treated as non-fatal");
    chk_fatal_torque_off: assert property (launch && launch_cls == safety_escalation_pkg::CL_FATAL
        && !sys_fault |=> o_reaction == 3'b010 && o_torque_off && o_stage_lock)
        else $error("fatal class did not disable torque");
    chk_timer_escalate: assert property (sup_fail && !use_dmon && !sys_fault && !new_err
        && class_r == safety_escalation_pkg::CL_NONFATAL
        |=> class_r == safety_escalation_pkg::CL_ORDINARY && o_escalated)
        else $error("tolerance expiry did not escalate");
    chk_decel_escalate: assert property (in_react && use_dmon && i_decel_trip && !sys_fault
        && class_r == safety_escalation_pkg::CL_ORDINARY |=> class_r == safety_escalation_pkg::CL_FATAL)
        else $error("deceleration monitor trip did not escalate");
    chk_off_after_done: assert property (in_react && i_reaction_done && !launch && !sys_fault
        |=> o_torque_off ##0 (o_brake_ctl == $past(i_brake_cfg)))
        else $error("completed reaction did not reach torque off");
    chk_default_state: assert property (sys_fault |=> o_stage_lock && !o_brake_open
        && o_local_outs == '0 && !o_axis_safe ##1 state_r == safety_escalation_pkg::ST_DEFAULT)
        else $error("safe default state not entered");
    chk_perm_unsafe: assert property (perm_fault |=> !o_axis_safe [*4])
        else $error("axis reported safe after permanent fault");
    chk_cfg_mismatch: assert property (i_transition_cmd |=> o_cfg_err == $past(cfg_mismatch))
        else $error("configuration mismatch flag wrong");
    chk_master_hold: assert property (seq_launch_master |=> o_master_stop_req && o_hold_monitors)
        else $error("master reaction not requested with held monitors");
    chk_coast_unsafe: assert property (state_r == safety_escalation_pkg::ST_OFF && !i_err_clear
        && !sys_fault && i_torque_free && !i_standstill && !perm_safe_r |=> !o_axis_safe)
        else $error("coasting axis reported safe");
    chk_react_ack_hold: assert property (seq_idle_err ##0 (launch_rx != safety_escalation_pkg::R_TORQUE_OFF)
        ##0 !perm_unsafe_nxt && !i_torque_free |=> o_axis_safe == $past(i_op_safe_ack))
        else $error("prior acknowledgment not held in reaction");
endmodule
`default_nettype wire

// ==== sim/drive_partner.sv ====
// behavioural drive control and motion master answering the stopping reaction
`timescale 1ns/1ps
`default_nettype none
module drive_partner
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // design side and bench delay, 8'hff stalls for good
    input wire logic i_status_ok,
    input wire logic i_torque_off,
    input wire logic [7:0] i_dly,
    // axis feedback
    output logic o_reaction_done,
    output logic o_torque_free,
    output logic o_standstill
);
    logic [7:0] cnt_r;
    // cycles since the error, saturating so a stall never wraps into done
    always @(negedge i_clk)
    begin
        if (i_sys_rst || i_status_ok)
            cnt_r <= 8'h00;
        else if (cnt_r != 8'hfe)
            cnt_r <= cnt_r + 8'h01;
    end
    // master or drive decelerates after the chosen delay
    assign o_reaction_done = (i_dly != 8'hff) && (cnt_r >= i_dly);
    assign o_torque_free = i_torque_off;
    assign o_standstill = i_torque_off && (cnt_r >= i_dly);
endmodule
`default_nettype wire

// ==== sim/test_safety_error_escalation.sv ====
// self-checking bench for the safety error escalation manager
`timescale 1ns/1ps
`default_nettype none
module test_safety_error_escalation;
    logic i_clk, i_sys_rst, i_mon_trig, i_special_mode, i_transition_cmd, i_enc_eval_active;
    logic i_brake_cfg, i_reaction_done, i_decel_trip, i_torque_free, i_standstill;
    logic i_op_safe_ack, i_err_clear, i_err_encoder, i_err_brake, i_err_ack_out;
    logic i_sys_err_own, i_fatal_std, i_brake_open_req;
    logic [2:0] i_mon_class, o_err_class, o_reaction;
    logic [16:0] i_stop_cfg, i_std_cfg;
    logic [15:0] i_tol_nonfatal, i_tol_ordinary;
    logic [3:0] i_local_outs, o_local_outs;
    logic o_status_ok, o_warn_quiet, o_escalated, o_cfg_err, o_axis_safe, o_master_stop_req;
    logic o_return_req, o_hold_monitors, o_torque_off, o_brake_ctl, o_stage_lock, o_brake_open;
    logic [7:0] dly;
    int n_mismatch, compares, cycles;

    // short tick keeps tolerance times to a few cycles
    safety_error_escalation #(.TICK_CYCLES(4)) u_safety_error_escalation
    (
        .i_clk, .i_sys_rst, .i_mon_trig, .i_mon_class, .i_special_mode, .i_stop_cfg,
        .i_std_cfg, .i_transition_cmd, .i_tol_nonfatal, .i_tol_ordinary, .i_enc_eval_active,
        .i_brake_cfg, .i_reaction_done, .i_decel_trip, .i_torque_free, .i_standstill,
        .i_op_safe_ack, .i_err_clear, .i_err_encoder, .i_err_brake, .i_err_ack_out,
        .i_sys_err_own, .i_fatal_std, .i_brake_open_req, .i_local_outs, .o_status_ok,
        .o_err_class, .o_warn_quiet, .o_escalated, .o_cfg_err, .o_axis_safe, .o_reaction,
        .o_master_stop_req, .o_return_req, .o_hold_monitors, .o_torque_off, .o_brake_ctl,
        .o_stage_lock, .o_brake_open, .o_local_outs
    );
    drive_partner u_drive_partner
    (
        .i_clk, .i_sys_rst, .i_status_ok(o_status_ok), .i_torque_off(o_torque_off),
        .i_dly(dly), .o_reaction_done(i_reaction_done), .o_torque_free(i_torque_free),
        .o_standstill(i_standstill)
    );

    always #25 i_clk = ~i_clk;
    // hang guard, far above the roughly 120 cycles the run needs
    always @(posedge i_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 4000)
        begin
            n_mismatch = n_mismatch + 1;
            close_out();
        end
    end

    task automatic chk(input string name, input logic [16:0] seen, input logic [16:0] exp);
        compares = compares + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic rst;
        i_sys_rst = 1'b1;
        cyc(4);
        i_sys_rst = 1'b0;
        cyc(1);
    endtask
    // one-cycle trigger; returns where the answer is visible
    task automatic trig(input logic [2:0] cls);
        i_mon_class = cls;
        i_mon_trig = 1'b1;
        cyc(1);
        i_mon_trig = 1'b0;
    endtask
    task automatic clr;
        i_err_clear = 1'b1;
        cyc(1);
        i_err_clear = 1'b0;
        chk("status_ok", o_status_ok, 1'b1);
    endtask
    // bounded wait on torque-off (sel 0) or the escalation pulse (sel 1)
    task automatic wait_hi(input int sel, input int lim);
        int k;
        k = 0;
        while (((sel == 0) ? o_torque_off : o_escalated) !== 1'b1 && k < lim)
        begin
            cyc(1);
            k++;
        end
    endtask
    task automatic xcmd(input logic [16:0] flip, input logic exp);
        i_std_cfg = i_stop_cfg ^ flip;
        i_transition_cmd = 1'b1;
        cyc(1);
        i_transition_cmd = 1'b0;
        cyc(1);
        chk("cfg_err", o_cfg_err, exp);
    endtask
    task automatic close_out;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        {i_clk, i_mon_trig, i_special_mode, i_transition_cmd, i_enc_eval_active, i_decel_trip,
            i_err_clear, i_err_encoder, i_err_brake, i_err_ack_out, i_sys_err_own, i_fatal_std} = '0;
        {i_op_safe_ack, i_brake_open_req, i_brake_cfg} = 3'b111;
        {i_mon_class, i_local_outs, i_tol_nonfatal, i_tol_ordinary} = {3'h0, 4'ha, 16'h2, 16'h8};
        {i_stop_cfg, i_std_cfg, dly, cycles, n_mismatch, compares} = {17'h2, 17'h2, 8'h5, 96'h0};
        rst();
        chk("status_ok", o_status_ok, 1'b1);
        chk("brake_open", o_brake_open, 1'b1);
        chk("local_outs", o_local_outs, 4'ha);
        trig(3'h1);
        chk("warn_quiet", o_warn_quiet, 1'b1);
        chk("status_ok", o_status_ok, 1'b1);
        cyc(1);
        // quick stop completes inside tolerance, then torque-off with brake
        trig(3'h3);
        chk("class", o_err_class, 3'h3);
        chk("reaction", o_reaction, 3'h3);
        chk("status_ok", o_status_ok, 1'b0);
        wait_hi(0, 20);
        chk("torque_off", o_torque_off, 1'b1);
        chk("brake_ctl", o_brake_ctl, 1'b1);
        chk("brake_open", o_brake_open, 1'b0);
        clr();
        // reacting warning, return motion stalls and escalates
        {i_stop_cfg, i_std_cfg, i_brake_cfg, dly} = {17'h3, 17'h3, 1'b0, 8'hff};
        trig(3'h2);
        chk("class", o_err_class, 3'h3);
        chk("reaction", o_reaction, 3'h4);
        chk("return_req", o_return_req, 1'b1);
        chk("hold", o_hold_monitors, 1'b1);
        i_op_safe_ack = 1'b0;
        cyc(2);
        chk("axis_safe", o_axis_safe, 1'b1);
        chk("escalated", o_escalated, 1'b0);
        i_op_safe_ack = 1'b1;
        wait_hi(1, 40);
        chk("escalated", o_escalated, 1'b1);
        chk("class", o_err_class, 3'h4);
        chk("reaction", o_reaction, 3'h1);
        dly = 8'h03;
        wait_hi(0, 20);
        chk("brake_ctl", o_brake_ctl, 1'b0);
        clr();
        // master-driven stop in special mode
        {i_special_mode, i_stop_cfg, i_std_cfg, dly} = {1'b1, 17'h10002, 17'h10002, 8'h4};
        trig(3'h3);
        chk("reaction", o_reaction, 3'h6);
        chk("master_req", o_master_stop_req, 1'b1);
        wait_hi(0, 20);
        chk("torque_off", o_torque_off, 1'b1);
        clr();
        // fatal: torque off at once, coasting then standstill
        dly = 8'h06;
        trig(3'h5);
        chk("class", o_err_class, 3'h5);
        wait_hi(0, 3);
        cyc(2);
        chk("axis_safe", o_axis_safe, 1'b0);
        cyc(8);
        chk("axis_safe", o_axis_safe, 1'b1);
        clr();
        // encoder active: deceleration monitor replaces the timer
        {i_special_mode, i_enc_eval_active, i_stop_cfg, i_std_cfg, dly} = {2'b01, 34'h4, 8'hff};
        trig(3'h3);
        cyc(20);
        chk("escalated", o_escalated, 1'b0);
        i_decel_trip = 1'b1;
        wait_hi(1, 4);
        chk("escalated", o_escalated, 1'b1);
        // trip held one more cycle: ordinary class escalates to fatal
        cyc(1);
        i_decel_trip = 1'b0;
        chk("class", o_err_class, 3'h5);
        xcmd(17'h10000, 1'b1);
        xcmd(17'h00000, 1'b0);
        xcmd(17'h00080, 1'b1);
        for (int k = 0; k < 5; k++)
        begin
            rst();
            chk("axis_safe", o_axis_safe, 1'b1);
            {i_err_encoder, i_err_brake, i_err_ack_out, i_sys_err_own, i_fatal_std} = 5'h10 >> k;
            cyc(1);
            {i_err_encoder, i_err_brake, i_err_ack_out, i_sys_err_own, i_fatal_std} = 5'h00;
            cyc(3);
            chk("axis_safe", o_axis_safe, 1'b0);
            chk("stage_lock", o_stage_lock, (k > 2) ? 1'b1 : 1'b0);
            chk("local_outs", o_local_outs, (k > 2) ? 4'h0 : 4'ha);
            chk("brake_open", o_brake_open, (k > 2) ? 1'b0 : 1'b1);
        end
        close_out();
    end
endmodule
`default_nettype wire
